// ===== verilog/lgpc_pkg.sv
// What this block does
// R1: Inhibit high forces all channel outputs off
// R2: Inhibit high holds grayscale counter at zero
// R3: Inhibit low lets grayscale compare drive outputs
// R4: Source select picks stored or volatile correction
// R5: Source select writes store only in program mode
// R6: Correction store resets to 3Fh per channel
// R7: Mode ground latches into grayscale register
// R8: Mode supply latches into correction register
// R9: Program mode plus select copies register to store
// R10: Open-drain error pulls low on fault
// R11: Latch high copies shift data per mode
// R12: Latch low keeps both registers unchanged
// R13: Counter advances on grayscale reference clock edges
// R14: Rising shift clock captures serial bit, MSB first
// R15: Host shifts 96 or 192 bits, then latches
// R16: Serial out shows bit leaving shift register
// R17: Open-LED bits captured on latch falling edge
// R18: Channel on while counter below its value
// R19: Shifting never disturbs outputs before latch
package lgpc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int LGPC_NUM_CH = 16;
    localparam int LGPC_GRAYSCALE_W = 12;
    localparam int LGPC_DC_W = 6;
    localparam int LGPC_GRAYSCALE_BITS = LGPC_NUM_CH * LGPC_GRAYSCALE_W;
    localparam int LGPC_DC_BITS = LGPC_NUM_CH * LGPC_DC_W;
    localparam int LGPC_FIFO_W = 1;
    localparam int LGPC_FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // Status word positions inside the shift register
    // ------------------------------------------------------------
    localparam int LGPC_ST_OPEN_LED_POS = 176;
    localparam int LGPC_ST_OVER_TEMP_POS = 175;
    localparam int LGPC_ST_WIRE_POS = 174;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [LGPC_NUM_CH-1:0][LGPC_GRAYSCALE_W-1:0] lgpc_grayscale_t;
    typedef logic [LGPC_NUM_CH-1:0][LGPC_DC_W-1:0] lgpc_dc_t;

    // Reset image of the correction store
    localparam lgpc_dc_t LGPC_NV_RESET = {LGPC_NUM_CH{6'h3f}};
    localparam logic [LGPC_GRAYSCALE_W-1:0] LGPC_CNT_RESET = 12'h000;

    // Load mode pin levels: ground, supply, programming voltage
    typedef enum logic [1:0] {
        LGPC_MODE_GRAYSCALE = 2'b00,
        LGPC_MODE_DOT_CORRECTION = 2'b01,
        LGPC_MODE_PROGRAM = 2'b10
    } lgpc_mode_t;

    // Fault sense inputs from the analog side
    typedef struct packed {
        logic [LGPC_NUM_CH-1:0] open_led_detect;
        logic over_temperature_flag;
    } lgpc_err_t;

    // Link-domain state
    typedef struct packed {
        logic rst_m;
        logic rst_s;
        logic bit_r;
        logic tog_r;
    } lgpc_link_t;

    // Core-domain state
    typedef struct packed {
        logic latch_m;
        logic latch_s;
        logic latch_d;
        logic blank_m;
        logic blank_s;
        logic gsclk_m;
        logic gsclk_s;
        logic gsclk_d;
        logic csel_m;
        logic csel_s;
        logic [1:0] mode_m;
        logic [1:0] mode_s;
        logic tog_m;
        logic tog_s;
        logic tog_d;
        lgpc_err_t err_m;
        lgpc_err_t err_s;
        logic wire_m;
        logic wire_s;
        logic [LGPC_GRAYSCALE_BITS-1:0] shift;
        lgpc_grayscale_t grayscale;
        lgpc_dc_t dc;
        lgpc_dc_t nv;
        logic [LGPC_GRAYSCALE_W-1:0] cnt;
        logic [LGPC_NUM_CH-1:0] out;
        lgpc_dc_t dco;
        logic so;
        logic err_pull;
    } lgpc_core_t;

endpackage

// ===== verilog/lgpc_fifo.sv
`timescale 1ns/100ps
module lgpc_fifo import lgpc_pkg::*; #(
    parameter int WIDTH = LGPC_FIFO_W,
    parameter int DEPTH = LGPC_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } lgpc_fifo_st_t;

    lgpc_fifo_st_t st_r;
    lgpc_fifo_st_t st_nxt;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Flags come straight from the count, so full and empty are exact
    // ------------------------------------------------------------
    assign in_ready_o = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st_r.cnt != '0);
    assign out_data_o = st_r.mem[st_r.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer wrap handles depths that are not a power of two
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data_i;
            st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
        if (!rst_n_i) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

endmodule

// ===== verilog/lgpc_core.sv
`timescale 1ns/100ps
module lgpc_core import lgpc_pkg::*; (
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire logic SHIFT_CLK_I,
    input wire logic SERIAL_IN_I,
    input wire logic REGISTER_LATCH_I,
    input wire logic [1:0] LOAD_MODE_SELECT_I,
    input wire logic CORRECTION_SOURCE_SELECT_I,
    input wire logic OUTPUT_INHIBIT_I,
    input wire logic GRAYSCALE_REF_CLK_I,
    input wire lgpc_err_t ERROR_SENSE_I,
    input wire logic ERROR_OPEN_DRAIN_OUT_I,
    output logic ERROR_OPEN_DRAIN_OUT_O,
    output logic ERROR_OPEN_DRAIN_OUT_OEN_O,
    output logic SERIAL_OUT_O,
    output logic [LGPC_NUM_CH-1:0] CHANNEL_OUTPUT_O,
    output lgpc_dc_t DOT_CORRECTION_O,
    output logic SHIFT_READY_O
);

    lgpc_link_t lk_r;
    lgpc_link_t lk_nxt;
    lgpc_core_t c_r;
    lgpc_core_t c_nxt;
    logic gsclk_rise;
    logic latch_fall;
    logic bit_evt;
    logic fifo_valid;
    logic fifo_bit;
    logic pop;
    logic mode_grayscale;
    logic mode_prog;

    // ------------------------------------------------------------
    // Link domain: capture on the shift clock
    // ------------------------------------------------------------
    // Each rising edge grabs the bit and flips a toggle; the bit is held
    // a full link period, far longer than the core needs to see the toggle
    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.rst_m = RESETN_I;
        lk_nxt.rst_s = lk_r.rst_m;
        lk_nxt.bit_r = SERIAL_IN_I;  // [R14]
        lk_nxt.tog_r = ~lk_r.tog_r;
        if (!lk_r.rst_s) begin
            lk_nxt.bit_r = 1'b0;
            lk_nxt.tog_r = 1'b0;
        end
    end

    always_ff @(posedge SHIFT_CLK_I) begin
        lk_r <= lk_nxt;
    end

    // ------------------------------------------------------------
    // Bit stream buffer
    // ------------------------------------------------------------
    // Drain stalls while a latch is in progress, so bits shifted then wait
    lgpc_fifo #(
        .WIDTH(LGPC_FIFO_W),
        .DEPTH(LGPC_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESETN_I),
        .in_valid_i(bit_evt),
        .in_ready_o(SHIFT_READY_O),
        .in_data_i(lk_r.bit_r),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_bit)
    );

    // ------------------------------------------------------------
    // Core domain events
    // ------------------------------------------------------------
    assign gsclk_rise = c_r.gsclk_s & ~c_r.gsclk_d;
    assign latch_fall = c_r.latch_d & ~c_r.latch_s;
    assign bit_evt = c_r.tog_s ^ c_r.tog_d;
    assign mode_grayscale = (c_r.mode_s == LGPC_MODE_GRAYSCALE);
    assign mode_prog = (c_r.mode_s == LGPC_MODE_PROGRAM);
    assign pop = fifo_valid && !c_r.latch_s && !latch_fall;

    // ------------------------------------------------------------
    // Core next state
    // ------------------------------------------------------------
    always_comb begin
        c_nxt = c_r;
        // Two-flop synchronisers for every control and sense pin; reset is used unsynchronised
        c_nxt.latch_m = REGISTER_LATCH_I;
        c_nxt.latch_s = c_r.latch_m;
        c_nxt.latch_d = c_r.latch_s;
        c_nxt.blank_m = OUTPUT_INHIBIT_I;
        c_nxt.blank_s = c_r.blank_m;
        c_nxt.gsclk_m = GRAYSCALE_REF_CLK_I;
        c_nxt.gsclk_s = c_r.gsclk_m;
        c_nxt.gsclk_d = c_r.gsclk_s;
        c_nxt.csel_m = CORRECTION_SOURCE_SELECT_I;
        c_nxt.csel_s = c_r.csel_m;
        c_nxt.mode_m = LOAD_MODE_SELECT_I;
        c_nxt.mode_s = c_r.mode_m;
        c_nxt.tog_m = lk_r.tog_r;
        c_nxt.tog_s = c_r.tog_m;
        c_nxt.tog_d = c_r.tog_s;
        c_nxt.err_m = ERROR_SENSE_I;
        c_nxt.err_s = c_r.err_m;
        c_nxt.wire_m = ERROR_OPEN_DRAIN_OUT_I;
        c_nxt.wire_s = c_r.wire_m;

        // Grayscale counter held at zero while inhibited
        if (c_r.blank_s) begin
            c_nxt.cnt = LGPC_CNT_RESET;  // [R2]
        end else if (gsclk_rise) begin
            c_nxt.cnt = c_r.cnt + 1'b1;  // [R13]
        end

        // Channel compare; inhibit overrides any grayscale value
        for (int i = 0; i < LGPC_NUM_CH; i++) begin
            c_nxt.out[i] = !c_r.blank_s && (c_r.cnt < c_r.grayscale[i]);  // [R1] [R3] [R18]
        end

        // Level latch: transparent for as long as the pin stays high
        if (c_r.latch_s) begin  // [R12]
            if (mode_grayscale) begin
                c_nxt.grayscale = c_r.shift;  // [R7] [R11]
            end else begin
                c_nxt.dc = c_r.shift[LGPC_DC_BITS-1:0];  // [R8] [R11]
            end
        end

        // Store write only at the programming level
        if (mode_prog && c_r.csel_s) begin
            c_nxt.nv = c_r.dc;  // [R5] [R9]
        end

        // Correction source mux, registered to keep the output glitch free
        c_nxt.dco = c_r.csel_s ? c_r.dc : c_r.nv;  // [R4]

        // Shift register: status image on latch fall, else one bit per pop
        if (latch_fall) begin
            c_nxt.shift = '0;
            c_nxt.shift[LGPC_ST_OPEN_LED_POS +: LGPC_NUM_CH] = c_r.err_s.open_led_detect;  // [R17]
            c_nxt.shift[LGPC_ST_OVER_TEMP_POS] = c_r.err_s.over_temperature_flag;
            c_nxt.shift[LGPC_ST_WIRE_POS] = c_r.wire_s;
        end else if (pop) begin
            c_nxt.shift = {c_r.shift[LGPC_GRAYSCALE_BITS-2:0], fifo_bit};  // [R14] [R19]
        end

        // Chain output taps the end of the active frame length
        c_nxt.so = mode_grayscale ? c_r.shift[LGPC_GRAYSCALE_BITS-1] : c_r.shift[LGPC_DC_BITS-1];  // [R16]

        // Open-LED only counts on a channel that is switched on
        c_nxt.err_pull = c_r.err_s.over_temperature_flag
            | (|(c_r.err_s.open_led_detect & c_r.out));  // [R10]

        if (!RESETN_I) begin
            c_nxt = '0;
            c_nxt.nv = LGPC_NV_RESET;  // [R6]
            c_nxt.dco = LGPC_NV_RESET;
            c_nxt.cnt = LGPC_CNT_RESET;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        c_r <= c_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open drain: the pin is only ever pulled low, never driven high
    assign ERROR_OPEN_DRAIN_OUT_O = 1'b0;
    assign ERROR_OPEN_DRAIN_OUT_OEN_O = ~c_r.err_pull;  // [R10]
    assign SERIAL_OUT_O = c_r.so;
    assign CHANNEL_OUTPUT_O = c_r.out;
    assign DOT_CORRECTION_O = c_r.dco;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_latch_fall;
        c_r.latch_s ##1 !c_r.latch_s;
    endsequence

    sequence s_latch_grayscale;
        c_r.latch_s && mode_grayscale;
    endsequence

    property p_inhibit_off;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        c_r.blank_s [*2] |-> CHANNEL_OUTPUT_O == '0;
    endproperty
    a_inhibit_off: assert property (p_inhibit_off) else $error("Outputs on while inhibited"); // [R1]

    property p_inhibit_cnt;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        c_r.blank_s |=> c_r.cnt == '0;
    endproperty
    a_inhibit_cnt: assert property (p_inhibit_cnt) else $error("Counter runs while inhibited"); // [R2]

    property p_compare;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        !c_r.blank_s |=> CHANNEL_OUTPUT_O[0] == ($past(c_r.cnt) < $past(c_r.grayscale[0]));
    endproperty
    a_compare: assert property (p_compare) else $error("Channel 0 compare wrong"); // [R3]

    property p_source;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        !c_r.csel_s |=> DOT_CORRECTION_O == $past(c_r.nv);
    endproperty
    a_source: assert property (p_source) else $error("Correction not from store"); // [R4]

    property p_program;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        mode_prog && c_r.csel_s |=> c_r.nv == $past(c_r.dc);
    endproperty
    a_program: assert property (p_program) else $error("Store not programmed"); // [R9]

    property p_no_program;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        !mode_prog |=> $stable(c_r.nv);
    endproperty
    a_no_program: assert property (p_no_program) else $error("Store written outside program mode"); // [R5]

    property p_latch_grayscale;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        s_latch_grayscale |=> c_r.grayscale == $past(c_r.shift);
    endproperty
    a_latch_grayscale: assert property (p_latch_grayscale) else $error("Grayscale not latched"); // [R11]

    property p_hold;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        !c_r.latch_s |=> $stable(c_r.grayscale) && $stable(c_r.dc);
    endproperty
    a_hold: assert property (p_hold) else $error("Registers changed without latch"); // [R12]

    property p_status;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        s_latch_fall |=> c_r.shift[LGPC_ST_OPEN_LED_POS +: LGPC_NUM_CH] == $past(c_r.err_s.open_led_detect);
    endproperty
    a_status: assert property (p_status) else $error("Status not captured"); // [R17]

    property p_error;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        c_r.err_s.over_temperature_flag |=> !ERROR_OPEN_DRAIN_OUT_OEN_O;
    endproperty
    a_error: assert property (p_error) else $error("Error pin not pulled"); // [R10]

    property p_count;
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        gsclk_rise && !c_r.blank_s |=> c_r.cnt == $past(c_r.cnt) + 12'h001;
    endproperty
    a_count: assert property (p_count) else $error("Counter did not advance"); // [R13]

endmodule

// ===== verification/lgpc_host_model.sv
`timescale 1ns/100ps
module lgpc_host_model (
    output logic shift_clk_o,
    output logic serial_in_o
);
    // ----------------------------------------
    // Serial host
    // ----------------------------------------
    initial begin
        shift_clk_o = 1'b0;
        serial_in_o = 1'b0;
    end

    // MSB first, data set up half a period before the rising edge
    // Clock stands still between frames; the line flips so a stale bit is never read as valid
    // A half-period rest after the flip keeps back-to-back frames from driving the line twice at once
    task automatic send(input logic [191:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_o = v[i];
            #15 shift_clk_o = 1'b1;
            #15 shift_clk_o = 1'b0;
        end
        serial_in_o = ~serial_in_o;
        #15;
    endtask
endmodule

// ===== verification/led_grayscale_pwm_control_tb_top.sv
`timescale 1ns/100ps
module led_grayscale_pwm_control_tb_top import lgpc_pkg::*;;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam lgpc_dc_t nv_def = {16{6'h3f}};
    logic clk, rst_n, latch, csel, inhibit, ref_clk, ready, chain_out, oen, od_o;
    logic [1:0] mode;
    lgpc_err_t err_sense;
    logic [LGPC_NUM_CH-1:0] chan;
    lgpc_dc_t dco;
    lgpc_dc_t dcf;
    logic [191:0] gsf;
    wire shift_clk;
    wire ser_data;
    wire err_wire;
    int err_total;
    int n_checks;

    // Pull-up on the shared error wire while nobody pulls it low
    assign err_wire = oen ? 1'b1 : od_o;

    // Core clock, 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    lgpc_host_model host_u (.shift_clk_o(shift_clk), .serial_in_o(ser_data));

    lgpc_core dut_u (
        .CORE_CLK_I(clk), .RESETN_I(rst_n), .SHIFT_CLK_I(shift_clk), .SERIAL_IN_I(ser_data),
        .REGISTER_LATCH_I(latch), .LOAD_MODE_SELECT_I(mode), .CORRECTION_SOURCE_SELECT_I(csel),
        .OUTPUT_INHIBIT_I(inhibit), .GRAYSCALE_REF_CLK_I(ref_clk), .ERROR_SENSE_I(err_sense),
        .ERROR_OPEN_DRAIN_OUT_I(err_wire), .ERROR_OPEN_DRAIN_OUT_O(od_o),
        .ERROR_OPEN_DRAIN_OUT_OEN_O(oen), .SERIAL_OUT_O(chain_out), .CHANNEL_OUTPUT_O(chan),
        .DOT_CORRECTION_O(dco), .SHIFT_READY_O(ready)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic pulse_latch;
        latch = 1'b1;
        cyc(4);
        latch = 1'b0;
        cyc(8);
    endtask

    // Ref clock kept 4 core cycles each level, above the sync minimum
    task automatic tick(input int n);
        repeat (n) begin
            ref_clk = 1'b1;
            cyc(4);
            ref_clk = 1'b0;
            cyc(4);
        end
        cyc(4);
    endtask

    function automatic logic [15:0] pwm_exp(input int k);
        for (int n = 0; n < LGPC_NUM_CH; n++) begin
            pwm_exp[n] = k < gsf[12*n +: 12];
        end
    endfunction

    // Hang guard, far beyond the expected run of about 10 us
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        latch = 1'b0;
        mode = LGPC_MODE_GRAYSCALE;
        csel = 1'b0;
        inhibit = 1'b0;
        ref_clk = 1'b0;
        err_sense = '0;
        err_total = 0;
        n_checks = 0;
        for (int n = 0; n < LGPC_NUM_CH; n++) begin
            gsf[12*n +: 12] = 12'(n);
        end
        gsf[191:180] = 12'h80f;
        dcf = 96'h0123456789abcdef01234567;
        cyc(1);
        // Link side needs shift clock edges while reset is low
        fork
            cyc(8);
            host_u.send('0, 4);
        join
        // Back on the falling edge before reset is released
        cyc(1);
        rst_n = 1'b1;
        cyc(2);
        chk(96'(oen), 96'h1);
        chk(dco, nv_def);
        // Leading dummy bits cover the link reset release; the one that is captured falls off the top
        host_u.send('0, 3);
        host_u.send(gsf, 192);
        cyc(10);
        chk(96'(chan), 96'h0);
        chk(96'(chain_out), 96'h1);
        pulse_latch();
        chk(96'(chan), 96'(pwm_exp(0)));
        tick(5);
        chk(96'(chan), 96'(pwm_exp(5)));
        inhibit = 1'b1;
        cyc(6);
        chk(96'(chan), 96'h0);
        inhibit = 1'b0;
        cyc(6);
        chk(96'(chan), 96'(pwm_exp(0)));
        err_sense.over_temperature_flag = 1'b1;
        cyc(6);
        chk(96'(oen), 96'h0);
        chk(96'(od_o), 96'h0);
        err_sense = '0;
        cyc(6);
        chk(96'(oen), 96'h1);
        err_sense.open_led_detect = 16'h8000;
        cyc(6);
        chk(96'(oen), 96'h0);
        pulse_latch();
        chk(96'(chain_out), 96'h1);
        err_sense = '0;
        cyc(6);
        chk(96'(oen), 96'h1);
        host_u.send('0, 1);
        cyc(10);
        chk(96'(chain_out), 96'h0);
        // Correction frame, then store selection and programming
        mode = LGPC_MODE_DOT_CORRECTION;
        host_u.send({96'h0, dcf}, 96);
        cyc(10);
        pulse_latch();
        // The status latch copied the status image into grayscale: only the
        // wire-level bit is set, which lands in channel 14 as value 040h
        chk(96'(chan), 96'h4000);
        csel = 1'b1;
        cyc(6);
        chk(dco, dcf);
        csel = 1'b0;
        cyc(6);
        chk(dco, nv_def);
        mode = LGPC_MODE_PROGRAM;
        csel = 1'b1;
        cyc(6);
        chk(dco, dcf);
        mode = LGPC_MODE_GRAYSCALE;
        csel = 1'b0;
        cyc(6);
        chk(dco, dcf);
        // Held latch stalls the bit buffer until it refuses, then it drains
        mode = LGPC_MODE_DOT_CORRECTION;
        latch = 1'b1;
        cyc(4);
        host_u.send('0, 17);
        cyc(1);
        chk(96'(ready), 96'h0);
        latch = 1'b0;
        cyc(12);
        chk(96'(ready), 96'h1);
        give_verdict();
    end
endmodule
